// ### asp_defs.vh
/*
 * Constants for the addressable serial port: register word indices,
 * bit positions, reset values and bit-timing counts.
 * Assumes inclusion by the design file only; definitions only.
 */
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH

// word index on the avalon address bus
`define ASP_ADR_TXSC   3'h0
`define ASP_ADR_RXSC   3'h1
`define ASP_ADR_BAUD   3'h2
`define ASP_ADR_TXDATA 3'h3
`define ASP_ADR_RXBUF  3'h4
`define ASP_ADR_PORT   3'h5

// tx_status_control bits
`define ASP_TX_CLKSRC 7
`define ASP_TX_NINE   6
`define ASP_TX_EN     5
`define ASP_TX_SYNC   4
`define ASP_TX_HIGH   2
`define ASP_TX_EMPTY  1
`define ASP_TX_NINTH  0

// rx_status_control bits
`define ASP_RX_PORTEN 7
`define ASP_RX_NINE   6
`define ASP_RX_SINGLE 5
`define ASP_RX_CONT   4
`define ASP_RX_ADRDET 3

// port control bit
`define ASP_PORT_OD 0

// reset values
`define ASP_TXSC_RST 8'h02
`define ASP_RXSC_RST 8'h00
`define ASP_BAUD_RST 8'h00
`define ASP_PORT_RST 8'h00

// timing: 16 samples per async bit, low speed adds a divide by 4
`define ASP_SAMP_LAST  4'hF
`define ASP_VOTE_A     4'h7
`define ASP_VOTE_B     4'h8
`define ASP_VOTE_C     4'h9
`define ASP_PRESC_LAST 2'h3
// sync master: 4 baud ticks per bit, clock high in phases 2 and 3
`define ASP_PH_RISE    2'h1
`define ASP_PH_FALL    2'h3

// one-hot receive states
`define ASP_RX_IDLE  4'h1
`define ASP_RX_START 4'h2
`define ASP_RX_DATA  4'h4
`define ASP_RX_STOP  4'h8

`endif

// ### asp_top.v
/*
 * Addressable serial port: async full duplex, sync master and sync
 * slave half duplex, 8/9-bit frames, address detect, baud generator,
 * Avalon-MM register slave with waitrequest.
 * Assumes one 10 MHz clock; pin inputs synchronous to it; the bench
 * resolves the two pins from the out/oe pairs.
 */
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "asp_defs.vh"

// Summary of operation
// - async, sync master, sync slave modes
// - port_enable clear holds port in reset
// - data pin direction switched by hardware
// - open-drain transmit pin drives only low
// - clock_source_sel picks master or slave clock
// - tx_nine_bit_sel selects 9-bit transmit
// - tx_enable; receive enables override it in sync
// - clocked_mode_sel picks sync; bit 3 zero
// - high_speed_sel picks async divisor
// - tx_shift_empty read-only, resets to one
// - tx_ninth_bit is transmitted ninth bit
// - rx_nine_bit_sel selects 9-bit receive
// - single_rx_enable: one master word, self-clearing
// - cont_rx_enable receives, beats single_rx_enable
// - async 9-bit address detect keeps only ninth-bit-one frames
// - framing_err follows the buffered word
// - overrun_err cleared by clearing cont_rx_enable or port_enable
// - rx_ninth_bit holds received ninth bit
// - 8-bit free-running baud timer, all modes
// - divisor write restarts baud timer
// - rate divides by 64, 16, 4 times n+1
// - three samples per async bit, majority vote

module asp_top (
    input  wire        clk_sys_i,
    input  wire        rst_i,
    input  wire [2:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    input  wire        transmit_or_clock_pin_i,
    output reg         transmit_or_clock_pin_o,
    output reg         transmit_or_clock_pin_oe_o,
    input  wire        receive_or_data_pin_i,
    output reg         receive_or_data_pin_o,
    output reg         receive_or_data_pin_oe_o
);

    // reset images, sliced per field below
    localparam [7:0] TXSC_RST = `ASP_TXSC_RST;
    localparam [7:0] RXSC_RST = `ASP_RXSC_RST;
    localparam [7:0] PORT_RST = `ASP_PORT_RST;

    // software registers
    reg        clock_source_sel_reg;
    reg        tx_nine_bit_sel_reg;
    reg        tx_enable_reg;
    reg        clocked_mode_sel_reg;
    reg        high_speed_sel_reg;
    reg        tx_ninth_bit_reg;
    reg        port_enable_reg;
    reg        rx_nine_bit_sel_reg;
    reg        single_rx_enable_reg;
    reg        cont_rx_enable_reg;
    reg        addr_detect_en_reg;
    reg        framing_err_reg;
    reg        overrun_err_reg;
    reg        rx_ninth_bit_reg;
    reg [7:0]  baud_divisor_reg;
    reg        tx_open_drain_sel_reg;
    reg [7:0]  receive_buffer_reg;
    reg        rx_full_reg;
    reg [8:0]  tx_hold_reg;
    reg        tx_hold_full_reg;

    // engine state
    reg [7:0]  baud_cnt_reg;
    reg [1:0]  presc_reg;
    reg [1:0]  phase_reg;
    reg        ck_prev_reg;
    reg [10:0] tx_shift_reg;
    reg [3:0]  tx_left_reg;
    reg        tx_busy_reg;
    reg [3:0]  tx_samp_reg;
    reg [3:0]  rx_state_reg;
    reg [3:0]  rx_samp_reg;
    reg [3:0]  rx_bits_reg;
    reg [8:0]  rx_shift_reg;
    reg        vote_a_reg;
    reg        vote_b_reg;

    wire wr_acc   = avs_write_i & ~avs_waitrequest_o;
    wire rd_acc   = avs_read_i & ~avs_waitrequest_o;
    wire en       = port_enable_reg;
    wire sync     = clocked_mode_sel_reg;
    wire master   = sync & clock_source_sel_reg;
    wire baud_wr  = wr_acc & (avs_address_i == `ASP_ADR_BAUD);
    wire rd_rxbuf = rd_acc & (avs_address_i == `ASP_ADR_RXBUF);
    wire wr_txd   = wr_acc & (avs_address_i == `ASP_ADR_TXDATA);

    // receive enables win over tx_enable in sync modes
    wire sync_rx  = sync & (cont_rx_enable_reg |
                    (single_rx_enable_reg & master));
    wire baud_tick = (baud_cnt_reg == baud_divisor_reg);
    // low speed: 4 ticks per sample gives 64(n+1) per bit
    wire samp_tick = baud_tick &
        (high_speed_sel_reg | (presc_reg == `ASP_PRESC_LAST));

    // sync clock events: own clock when master, pin edges when slave
    wire run      = master & (sync_rx | tx_busy_reg);
    wire ck_rise  = master ? (run & baud_tick &
                              (phase_reg == `ASP_PH_RISE))
                           : (transmit_or_clock_pin_i & ~ck_prev_reg);
    wire ck_fall  = master ? (run & baud_tick &
                              (phase_reg == `ASP_PH_FALL))
                           : (~transmit_or_clock_pin_i & ck_prev_reg);

    wire [3:0] rx_nbits = rx_nine_bit_sel_reg ? 4'h9 : 4'h8;
    wire [3:0] tx_nbits = tx_nine_bit_sel_reg ? 4'h9 : 4'h8;
    wire rx_pin = receive_or_data_pin_i;
    wire maj = (vote_a_reg & vote_b_reg) | (vote_a_reg & rx_pin) |
               (vote_b_reg & rx_pin);
    wire vote_pt = samp_tick & (rx_samp_reg == `ASP_VOTE_C);
    wire bit_end = samp_tick & (rx_samp_reg == `ASP_SAMP_LAST);
    wire rx_bit  = sync ? rx_pin : maj;
    wire [8:0] rx_new = {rx_bit, rx_shift_reg[8:1]};

    wire tx_load = en & tx_hold_full_reg & ~tx_busy_reg &
                   tx_enable_reg & ~sync_rx;

    // word completion, shared by async and sync receivers
    reg        rx_done;
    reg        rx_framing_err;
    reg [8:0]  rx_word;
    always @* begin
        rx_done = 1'b0;
        rx_framing_err = 1'b0;
        rx_word = rx_nine_bit_sel_reg ? rx_shift_reg
                                      : {1'b0, rx_shift_reg[8:1]};
        if (sync) begin
            if (sync_rx & ck_rise & (rx_bits_reg == rx_nbits - 4'h1)) begin
                rx_done = 1'b1;
                rx_word = rx_nine_bit_sel_reg ? rx_new
                                              : {1'b0, rx_new[8:1]};
            end
        end else if ((rx_state_reg == `ASP_RX_STOP) & vote_pt) begin
            rx_framing_err = ~maj;
            // address detect drops frames whose ninth bit is clear
            rx_done = ~(rx_nine_bit_sel_reg & addr_detect_en_reg &
                        ~rx_shift_reg[8]);
        end
    end

    // a read of the buffer in the same edge frees it for the new word
    wire buf_busy = rx_full_reg & ~rd_rxbuf;
    wire rx_store = rx_done & ~buf_busy;
    wire rx_ovr   = rx_done & buf_busy;

    // pin drive, registered below
    reg ck_lvl;
    reg ck_drv;
    reg dt_lvl;
    reg dt_drv;
    always @* begin
        ck_lvl = 1'b0;
        ck_drv = 1'b0;
        dt_lvl = 1'b0;
        dt_drv = 1'b0;
        if (en) begin
            if (!sync) begin
                ck_lvl = tx_busy_reg ? tx_shift_reg[0] : 1'b1;
                ck_drv = 1'b1;
            end else begin
                ck_lvl = run & phase_reg[1];
                ck_drv = master;
                dt_lvl = tx_shift_reg[0];
                dt_drv = tx_busy_reg & ~sync_rx;
            end
        end
        if (tx_open_drain_sel_reg) begin
            ck_drv = ck_drv & ~ck_lvl;
            ck_lvl = 1'b0;
        end
    end

    reg [7:0] rd_val;
    always @* begin
        case (avs_address_i)
            `ASP_ADR_TXSC:
                rd_val = {clock_source_sel_reg, tx_nine_bit_sel_reg,
                          tx_enable_reg, clocked_mode_sel_reg, 1'b0,
                          high_speed_sel_reg, ~tx_busy_reg,
                          tx_ninth_bit_reg};
            `ASP_ADR_RXSC:
                rd_val = {port_enable_reg, rx_nine_bit_sel_reg,
                          single_rx_enable_reg, cont_rx_enable_reg,
                          addr_detect_en_reg, framing_err_reg,
                          overrun_err_reg, rx_ninth_bit_reg};
            `ASP_ADR_BAUD:   rd_val = baud_divisor_reg;
            `ASP_ADR_TXDATA: rd_val = tx_hold_reg[7:0];
            `ASP_ADR_RXBUF:  rd_val = receive_buffer_reg;
            `ASP_ADR_PORT:
                rd_val = {5'h00, rx_full_reg, tx_hold_full_reg,
                          tx_open_drain_sel_reg};
            default:         rd_val = 8'h00;
        endcase
    end

    // bus slave: one wait cycle, then the access edge
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h00000000;
        end else begin
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) &
                                   avs_waitrequest_o);
            if (avs_read_i & avs_waitrequest_o) begin
                avs_readdata_o <= {24'h000000, rd_val};
            end
        end
    end

    // software-visible registers
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            {clock_source_sel_reg, tx_nine_bit_sel_reg, tx_enable_reg,
             clocked_mode_sel_reg} <= TXSC_RST[7:4];
            high_speed_sel_reg    <= TXSC_RST[`ASP_TX_HIGH];
            tx_ninth_bit_reg      <= TXSC_RST[`ASP_TX_NINTH];
            {port_enable_reg, rx_nine_bit_sel_reg, single_rx_enable_reg,
             cont_rx_enable_reg, addr_detect_en_reg} <= RXSC_RST[7:3];
            baud_divisor_reg      <= `ASP_BAUD_RST;
            tx_open_drain_sel_reg <= PORT_RST[`ASP_PORT_OD];
        end else begin
            if (rx_done & sync & ~cont_rx_enable_reg) begin
                single_rx_enable_reg <= 1'b0;
            end
            if (wr_acc) begin
                case (avs_address_i)
                    `ASP_ADR_TXSC: begin
                        clock_source_sel_reg <=
                            avs_writedata_i[`ASP_TX_CLKSRC];
                        tx_nine_bit_sel_reg  <=
                            avs_writedata_i[`ASP_TX_NINE];
                        tx_enable_reg        <=
                            avs_writedata_i[`ASP_TX_EN];
                        clocked_mode_sel_reg <=
                            avs_writedata_i[`ASP_TX_SYNC];
                        high_speed_sel_reg   <=
                            avs_writedata_i[`ASP_TX_HIGH];
                        tx_ninth_bit_reg     <=
                            avs_writedata_i[`ASP_TX_NINTH];
                    end
                    `ASP_ADR_RXSC: begin
                        port_enable_reg      <=
                            avs_writedata_i[`ASP_RX_PORTEN];
                        rx_nine_bit_sel_reg  <=
                            avs_writedata_i[`ASP_RX_NINE];
                        // a software set beats the hardware clear
                        single_rx_enable_reg <=
                            avs_writedata_i[`ASP_RX_SINGLE];
                        cont_rx_enable_reg   <=
                            avs_writedata_i[`ASP_RX_CONT];
                        addr_detect_en_reg   <=
                            avs_writedata_i[`ASP_RX_ADRDET];
                    end
                    `ASP_ADR_BAUD:
                        baud_divisor_reg <= avs_writedata_i[7:0];
                    `ASP_ADR_PORT:
                        tx_open_drain_sel_reg <=
                            avs_writedata_i[`ASP_PORT_OD];
                    default: begin
                    end
                endcase
            end
        end
    end

    // baud generator and sync clock phase
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            baud_cnt_reg <= 8'h00;
            presc_reg    <= 2'h0;
            phase_reg    <= 2'h0;
            ck_prev_reg  <= 1'b0;
        end else if (!en || baud_wr) begin
            baud_cnt_reg <= 8'h00;
            presc_reg    <= 2'h0;
            phase_reg    <= 2'h0;
            ck_prev_reg  <= transmit_or_clock_pin_i;
        end else begin
            ck_prev_reg  <= transmit_or_clock_pin_i;
            baud_cnt_reg <= baud_tick ? 8'h00
                                      : baud_cnt_reg + 8'h01;
            if (baud_tick) begin
                presc_reg <= presc_reg + 2'h1;
            end
            if (!run) begin
                phase_reg <= 2'h0;
            end else if (baud_tick) begin
                phase_reg <= phase_reg + 2'h1;
            end
        end
    end

    // transmit holding register and shift register
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tx_hold_reg      <= 9'h000;
            tx_hold_full_reg <= 1'b0;
            tx_shift_reg     <= 11'h7FF;
            tx_left_reg      <= 4'h0;
            tx_busy_reg      <= 1'b0;
            tx_samp_reg      <= 4'h0;
        end else if (!en) begin
            tx_hold_full_reg <= 1'b0;
            tx_shift_reg     <= 11'h7FF;
            tx_left_reg      <= 4'h0;
            tx_busy_reg      <= 1'b0;
            tx_samp_reg      <= 4'h0;
        end else begin
            if (wr_txd) begin
                tx_hold_reg      <= {tx_ninth_bit_reg,
                                     avs_writedata_i[7:0]};
                tx_hold_full_reg <= 1'b1;
            end else if (tx_load) begin
                tx_hold_full_reg <= 1'b0;
            end
            if (tx_load) begin
                tx_busy_reg <= 1'b1;
                tx_samp_reg <= 4'h0;
                if (sync) begin
                    tx_shift_reg <= {2'h3, tx_hold_reg};
                    tx_left_reg  <= tx_nbits;
                end else begin
                    // start bit low, data lsb first, stop bit high
                    tx_shift_reg <= tx_nine_bit_sel_reg ?
                        {1'b1, tx_hold_reg, 1'b0} :
                        {2'h3, tx_hold_reg[7:0], 1'b0};
                    tx_left_reg  <= tx_nbits + 4'h2;
                end
            end else if (tx_busy_reg) begin
                if (sync ? ck_fall
                         : (samp_tick &&
                            tx_samp_reg == `ASP_SAMP_LAST)) begin
                    tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                    tx_left_reg  <= tx_left_reg - 4'h1;
                    if (tx_left_reg == 4'h1) begin
                        tx_busy_reg <= 1'b0;
                    end
                end
                if (samp_tick) begin
                    tx_samp_reg <= tx_samp_reg + 4'h1;
                end
            end
        end
    end

    // receiver: async state machine or sync shift on clock rise
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rx_state_reg <= `ASP_RX_IDLE;
            rx_samp_reg  <= 4'h0;
            rx_bits_reg  <= 4'h0;
            rx_shift_reg <= 9'h000;
            vote_a_reg   <= 1'b1;
            vote_b_reg   <= 1'b1;
        end else if (!en || (sync ? !sync_rx : !cont_rx_enable_reg)) begin
            rx_state_reg <= `ASP_RX_IDLE;
            rx_samp_reg  <= 4'h0;
            rx_bits_reg  <= 4'h0;
        end else if (sync) begin
            if (ck_rise) begin
                rx_shift_reg <= rx_new;
                rx_bits_reg  <= rx_done ? 4'h0 : rx_bits_reg + 4'h1;
            end
        end else begin
            if (samp_tick) begin
                rx_samp_reg <= rx_samp_reg + 4'h1;
                if (rx_samp_reg == `ASP_VOTE_A) begin
                    vote_a_reg <= rx_pin;
                end
                if (rx_samp_reg == `ASP_VOTE_B) begin
                    vote_b_reg <= rx_pin;
                end
            end
            case (rx_state_reg)
                `ASP_RX_IDLE: begin
                    rx_samp_reg <= 4'h0;
                    rx_bits_reg <= 4'h0;
                    if (!rx_pin) begin
                        rx_state_reg <= `ASP_RX_START;
                    end
                end
                `ASP_RX_START: begin
                    if (vote_pt && maj) begin
                        rx_state_reg <= `ASP_RX_IDLE;  // glitch, not start
                    end else if (bit_end) begin
                        rx_state_reg <= `ASP_RX_DATA;
                    end
                end
                `ASP_RX_DATA: begin
                    if (vote_pt) begin
                        rx_shift_reg <= rx_new;
                        rx_bits_reg  <= rx_bits_reg + 4'h1;
                    end
                    if (bit_end && rx_bits_reg == rx_nbits) begin
                        rx_state_reg <= `ASP_RX_STOP;
                    end
                end
                `ASP_RX_STOP: begin
                    // finish at mid stop bit to catch the next start
                    if (vote_pt) begin
                        rx_state_reg <= `ASP_RX_IDLE;
                    end
                end
                default: rx_state_reg <= `ASP_RX_IDLE;
            endcase
        end
    end

    // receive buffer and error flags
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            receive_buffer_reg <= 8'h00;
            rx_full_reg        <= 1'b0;
            framing_err_reg    <= 1'b0;
            overrun_err_reg    <= 1'b0;
            rx_ninth_bit_reg   <= 1'b0;
        end else if (!en) begin
            rx_full_reg     <= 1'b0;
            framing_err_reg <= 1'b0;
            overrun_err_reg <= 1'b0;
        end else begin
            if (rx_store) begin
                receive_buffer_reg <= rx_word[7:0];
                rx_ninth_bit_reg   <= rx_word[8];
                framing_err_reg    <= rx_framing_err;
                rx_full_reg        <= 1'b1;
            end else if (rd_rxbuf) begin
                rx_full_reg <= 1'b0;
            end
            // a new overrun wins over a clear in the same edge
            if (rx_ovr) begin
                overrun_err_reg <= 1'b1;
            end else if (!cont_rx_enable_reg) begin
                overrun_err_reg <= 1'b0;
            end
        end
    end

    // pins straight from flops; mode picks the drive
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            transmit_or_clock_pin_o    <= 1'b0;
            transmit_or_clock_pin_oe_o <= 1'b0;
            receive_or_data_pin_o      <= 1'b0;
            receive_or_data_pin_oe_o   <= 1'b0;
        end else begin
            transmit_or_clock_pin_o    <= ck_lvl;
            transmit_or_clock_pin_oe_o <= ck_drv;
            receive_or_data_pin_o      <= dt_lvl;
            receive_or_data_pin_oe_o   <= dt_drv;
        end
    end

endmodule

// ### asp_props.sv
/* port checker for asp_top, bound at the foot of this file.
   assumes registers change only through avalon writes */
`timescale 1ns/100ps
module asp_props (
    input wire        clk_sys_i, rst_i, avs_read_i, avs_write_i,
    input wire [2:0]  avs_address_i,
    input wire [31:0] avs_writedata_i, avs_readdata_o,
    input wire        avs_waitrequest_o,
    input wire        transmit_or_clock_pin_i, transmit_or_clock_pin_o,
    input wire        transmit_or_clock_pin_oe_o, receive_or_data_pin_i,
    input wire        receive_or_data_pin_o, receive_or_data_pin_oe_o
);
    reg  en_reg;
    wire wr = avs_write_i && !avs_waitrequest_o;
    wire rd = avs_read_i && !avs_waitrequest_o;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // port_enable shadow, taken at the edge the write lands
    always @(posedge clk_sys_i or posedge rst_i)
        if (rst_i) en_reg <= 1'b0;
        else if (wr && avs_address_i == 3'h1) en_reg <= avs_writedata_i[7];
    a_wait_one: assert property ((avs_read_i || avs_write_i) &&
        avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
    a_wait_short: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("wait low twice");
    a_wait_idle: assert property (!avs_read_i && !avs_write_i &&
        avs_waitrequest_o |=> avs_waitrequest_o) else $error("wait dropped");
    a_upper_zero: assert property (rd |-> avs_readdata_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (rd && avs_address_i[2:1] == 2'h3 |->
        avs_readdata_o == 32'h0) else $error("unmapped read not zero");
    a_gap_bit_zero: assert property (rd && avs_address_i == 3'h0 |->
        !avs_readdata_o[3]) else $error("tx control bit 3 set");
    a_read_stands: assert property ($changed(avs_readdata_o) |->
        $past(avs_read_i && avs_waitrequest_o)) else $error("read data moved");
    a_off_quiet: assert property (!en_reg && !$past(en_reg) |->
        !transmit_or_clock_pin_oe_o && !receive_or_data_pin_oe_o)
        else $error("pin driven while disabled");
endmodule
bind asp_top asp_props u_asp_props (.*);

// ### asp_peer.sv
/* far-side async serial device: drives the data line, listens on tx.
   assumes each task starts just after a clock edge */
`timescale 1ns/100ps
module asp_peer #(parameter int BIT = 16) (
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      line_o
);
    // released line reads high, as through a pull-up
    initial line_o = 1'b1;
    task automatic bits(input logic v);
        line_o <= v;
        repeat (BIT) @(posedge clk_i);
    endtask
    // start low, data lsb first, stop, one idle bit
    task automatic send(input logic [8:0] d, input int n, input logic s);
        bits(1'b0);
        for (int i = 0; i < n; i++) bits(d[i]);
        bits(s);
        bits(1'b1);
    endtask
    // mid-bit sampling; d[8] holds the stop bit
    task automatic recv(output logic [8:0] d);
        for (int k = 0; k < 4000 && line_i !== 1'b0; k++) @(posedge clk_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge clk_i);
            d[i] = line_i;
        end
    endtask
endmodule

// ### tb_top.sv
/* bench for asp_top: register and receive rows, then a transmit.
   assumes asp_peer on the pins and asp_props bound to asp_top */
`timescale 1ns/100ps
module tb_top;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [2:0] avs_address_i = 3'h0, a;
    logic [31:0] avs_writedata_i = 32'h0;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, peer_line, transmit_or_clock_pin_o;
    wire transmit_or_clock_pin_oe_o, receive_or_data_pin_o;
    wire receive_or_data_pin_oe_o;
    // tx pin pulled up, so open drain still idles high
    wire transmit_or_clock_pin_i = transmit_or_clock_pin_oe_o ?
        transmit_or_clock_pin_o : 1'b1;
    wire receive_or_data_pin_i = receive_or_data_pin_oe_o ?
        receive_or_data_pin_o : peer_line;
    int n_errors = 0, samples_checked = 0, cyc = 0;
    logic [1:0] op;
    logic [7:0] e, q;
    logic [8:0] d, frame;
    logic ck_seen = 1'b1;
    int nb = 0;
    // op 0 write and read back, 1 read, 2 send (a[1] nine bits, a[0] stop)
    logic [21:0] rows [26] = '{
        {2'd1,3'h0,9'h000,8'h02}, {2'd1,3'h1,9'h000,8'h00},
        {2'd0,3'h0,9'h0FF,8'hF7}, {2'd0,3'h2,9'h0A5,8'hA5},
        {2'd0,3'h1,9'h07F,8'h78}, {2'd0,3'h2,9'h000,8'h00},
        {2'd0,3'h6,9'h055,8'h00}, {2'd0,3'h5,9'h001,8'h01},
        {2'd0,3'h0,9'h024,8'h26}, {2'd0,3'h1,9'h090,8'h90},
        {2'd2,3'h1,9'h0A5,8'h00}, {2'd1,3'h1,9'h000,8'h90},
        {2'd1,3'h4,9'h000,8'hA5}, {2'd2,3'h0,9'h05A,8'h00},
        {2'd1,3'h1,9'h000,8'h94}, {2'd1,3'h4,9'h000,8'h5A},
        {2'd2,3'h1,9'h03C,8'h00}, {2'd2,3'h1,9'h07E,8'h00},
        {2'd1,3'h1,9'h000,8'h92}, {2'd1,3'h4,9'h000,8'h3C},
        {2'd0,3'h1,9'h080,8'h80}, {2'd0,3'h1,9'h0D8,8'hD8},
        {2'd2,3'h3,9'h011,8'h00}, {2'd2,3'h3,9'h142,8'h00},
        {2'd1,3'h1,9'h000,8'hD9}, {2'd1,3'h4,9'h000,8'h42}};
    initial forever #50 clk_sys_i = ~clk_sys_i;
    asp_top u_asp_top (.*);
    // 16(n+1) clocks a bit: high speed, divisor 0
    asp_peer #(.BIT(16)) u_asp_peer (.clk_i(clk_sys_i),
        .line_i(transmit_or_clock_pin_i), .line_o(peer_line));
    // ceiling far above the ~1400 cycles the run needs
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) n_errors++;
        if (cyc == 20000) close_out;
    end
    task automatic bus(input logic w, input logic [2:0] ad,
                       input logic [7:0] wd);
        @(posedge clk_sys_i);
        avs_address_i <= ad;
        avs_writedata_i <= {24'h0, wd};
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o[7:0];
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [7:0] ex, got);
        samples_checked++;
        if (got !== ex) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, ex, got);
        end
    endtask
    task automatic close_out;
        $display("compares %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            {op, a, d, e} = rows[i];
            if (op == 2'd2)
                u_asp_peer.send(d, a[1] ? 9 : 8, a[0]);
            else begin
                if (op == 2'd0)
                    bus(1'b1, a, d[7:0]);
                bus(1'b0, a, 8'h00);
                chk($sformatf("reg %0d", a), e, q);
            end
        end
        $display("register and receive rows done");
        fork
            u_asp_peer.recv(frame);
            bus(1'b1, 3'h3, 8'hC3);
        join
        chk("tx data", 8'hC3, frame[7:0]);
        chk("tx stop", 8'h01, {7'h0, frame[8]});
        $display("transmit done");
        bus(1'b1, 3'h1, 8'h00);
        // sync master, 4 clocks a bit: data taken at clock pin rise
        bus(1'b1, 3'h0, 8'hB0);
        bus(1'b1, 3'h1, 8'h80);
        fork
            bus(1'b1, 3'h3, 8'h96);
            for (int k = 0; k < 400 && nb < 8; k++) begin
                @(posedge clk_sys_i);
                if (transmit_or_clock_pin_i && !ck_seen) begin
                    frame[nb] = receive_or_data_pin_i;
                    nb++;
                end
                ck_seen = transmit_or_clock_pin_i;
            end
        join
        chk("sync data", 8'h96, frame[7:0]);
        $display("sync transmit done");
        // mid-run reset puts the registers back
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        bus(1'b0, 3'h0, 8'h00);
        chk("reset tx", 8'h02, q);
        bus(1'b0, 3'h1, 8'h00);
        chk("reset rx", 8'h00, q);
        $display("reset done");
        close_out;
    end
endmodule
